// ===== rtl/csm_top.sv
// command source merge: terminal and serial commands combined per function
//
// Notes on behaviour
// - reverse is counter-clockwise when the chosen terminal/serial combination asserts it
// - setup index is one plus the merged two-bit setup code
// - preset reference index uses the same merging and plus-one mapping
// - source codes: 0 terminal, 1 serial, 2 and, 3 or, on read and write
// - setup and preset source choices reset to or, code 3
// - serial-only is a selectable source for setup and preset
// - serial-only needs the serial bit; and needs both terminal and serial
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "csm_consts.svh"

module csm_top
  import csm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_reverse_terminal_input,
  input wire logic [1:0] i_setup_terminal,
  input wire logic [1:0] i_preset_terminal,
  output logic o_ccw,
  output logic [2:0] o_setup_idx,
  output logic [2:0] o_preset_idx
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_ff;
  logic rst_b_ff;

  // async assert, two-flop release so all logic leaves reset on one edge
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_b_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_b_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------
  // terminal input synchronisers
  // ----------------------------------------
  csm_cmd_type term_meta_ff;
  csm_cmd_type term_ff;

  // pins are asynchronous; only term_ff is read by logic
  always_ff @(posedge i_clk or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      term_meta_ff <= '0;
      term_ff <= '0;
    end else begin
      term_meta_ff <= {i_reverse_terminal_input, i_setup_terminal, i_preset_terminal};
      term_ff <= term_meta_ff;
    end
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  csm_src_type direction_source_choice_ff;
  csm_src_type setup_source_choice_ff;
  csm_src_type preset_source_choice_ff;
  csm_cmd_type serial_cmd_ff;
  csm_out_type out_ff;

  // source choices keep the raw two-bit code, no translation
  always_ff @(posedge i_clk or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      direction_source_choice_ff <= csm_src_type'(`CSM_DIR_SRC_RST);
      setup_source_choice_ff <= csm_src_type'(`CSM_SETUP_SRC_RST);
      preset_source_choice_ff <= csm_src_type'(`CSM_PRESET_SRC_RST);
    end else if (i_wr) begin
      case (i_addr)
        `CSM_REG_DIR_SRC: begin
          direction_source_choice_ff <= csm_src_type'(i_wdata[1:0]);
        end
        `CSM_REG_SETUP_SRC: begin
          setup_source_choice_ff <= csm_src_type'(i_wdata[1:0]);
        end
        `CSM_REG_PRESET_SRC: begin
          preset_source_choice_ff <= csm_src_type'(i_wdata[1:0]);
        end
        default: begin
        end
      endcase
    end
  end

  // serial command bits as delivered by the serial port logic
  always_ff @(posedge i_clk or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      serial_cmd_ff <= '0;
    end else if (i_wr && i_addr == `CSM_REG_SERIAL_CMD) begin
      serial_cmd_ff.reverse <= i_wdata[`CSM_CMD_REV_BIT];
      serial_cmd_ff.setup <= i_wdata[`CSM_CMD_SETUP_HI:`CSM_CMD_SETUP_LO];
      serial_cmd_ff.preset <= i_wdata[`CSM_CMD_PRESET_HI:`CSM_CMD_PRESET_LO];
    end
  end

  // read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_clk or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        `CSM_REG_DIR_SRC: o_rdata <= {30'h0, direction_source_choice_ff};
        `CSM_REG_SETUP_SRC: o_rdata <= {30'h0, setup_source_choice_ff};
        `CSM_REG_PRESET_SRC: o_rdata <= {30'h0, preset_source_choice_ff};
        `CSM_REG_SERIAL_CMD: o_rdata <= {27'h0, serial_cmd_ff.preset, serial_cmd_ff.setup,
                                         serial_cmd_ff.reverse};
        `CSM_REG_STATUS: o_rdata <= {20'h0, term_ff.preset, term_ff.setup, term_ff.reverse,
                                     out_ff.preset_idx, out_ff.setup_idx, out_ff.ccw};
        default: o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // merging
  // ----------------------------------------
  logic merged_rev;
  logic [1:0] merged_setup;
  logic [1:0] merged_preset;

  csm_merge_bits #(.WIDTH(1)) u_dir (
    .i_src(direction_source_choice_ff),
    .i_term(term_ff.reverse),
    .i_serial(serial_cmd_ff.reverse),
    .o_merged(merged_rev)
  );

  csm_merge_bits #(.WIDTH(2)) u_setup (
    .i_src(setup_source_choice_ff),
    .i_term(term_ff.setup),
    .i_serial(serial_cmd_ff.setup),
    .o_merged(merged_setup)
  );

  csm_merge_bits #(.WIDTH(2)) u_preset (
    .i_src(preset_source_choice_ff),
    .i_term(term_ff.preset),
    .i_serial(serial_cmd_ff.preset),
    .o_merged(merged_preset)
  );

  // code 0..3 maps to index 1..4
  function automatic logic [2:0] csm_to_index(input logic [1:0] code);
    csm_to_index = {1'b0, code} + `CSM_INDEX_BASE;
  endfunction

  // registered outputs, refreshed every cycle
  always_ff @(posedge i_clk or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      out_ff.ccw <= `CSM_CW;
      out_ff.setup_idx <= `CSM_INDEX_BASE;
      out_ff.preset_idx <= `CSM_INDEX_BASE;
    end else begin
      out_ff.ccw <= merged_rev;
      out_ff.setup_idx <= csm_to_index(merged_setup);
      out_ff.preset_idx <= csm_to_index(merged_preset);
    end
  end

  assign o_ccw = out_ff.ccw;
  assign o_setup_idx = out_ff.setup_idx;
  assign o_preset_idx = out_ff.preset_idx;

endmodule

// ===== rtl/csm_consts.svh
// constants for the command source merge block
`ifndef CSM_CONSTS_SVH
`define CSM_CONSTS_SVH

// source selection codes, also the value seen over the serial port
`define CSM_SRC_TERMINAL 2'h0
`define CSM_SRC_SERIAL 2'h1
`define CSM_SRC_AND 2'h2
`define CSM_SRC_OR 2'h3

// factory defaults per function
`define CSM_DIR_SRC_RST 2'h0
`define CSM_SETUP_SRC_RST 2'h3
`define CSM_PRESET_SRC_RST 2'h3

// register map, word addresses on the register port
`define CSM_REG_DIR_SRC 4'h0
`define CSM_REG_SETUP_SRC 4'h1
`define CSM_REG_PRESET_SRC 4'h2
`define CSM_REG_SERIAL_CMD 4'h3
`define CSM_REG_STATUS 4'h4

// serial command word field positions
`define CSM_CMD_REV_BIT 0
`define CSM_CMD_SETUP_LO 1
`define CSM_CMD_SETUP_HI 2
`define CSM_CMD_PRESET_LO 3
`define CSM_CMD_PRESET_HI 4

// merged code to index offset
`define CSM_INDEX_BASE 3'h1
`define CSM_CW 1'b0

`endif

// ===== rtl/csm_pkg.sv
// types for the command source merge block
package csm_pkg;

  typedef enum logic [1:0] {
    CSM_TERMINAL = 2'h0,
    CSM_SERIAL = 2'h1,
    CSM_AND = 2'h2,
    CSM_OR = 2'h3
  } csm_src_type;

  // terminal or serial command bits grouped together
  typedef struct packed {
    logic reverse;
    logic [1:0] setup;
    logic [1:0] preset;
  } csm_cmd_type;

  // merged results
  typedef struct packed {
    logic ccw;
    logic [2:0] setup_idx;
    logic [2:0] preset_idx;
  } csm_out_type;

endpackage

// ===== rtl/csm_merge_bits.sv
// per-bit source merge of terminal and serial commands
`timescale 1ns/1ps
`include "csm_consts.svh"

module csm_merge_bits
  import csm_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input wire logic [1:0] i_src,
  input wire logic [WIDTH-1:0] i_term,
  input wire logic [WIDTH-1:0] i_serial,
  output logic [WIDTH-1:0] o_merged
);

  // plain case on the selection code; every code is legal
  always_comb begin
    case (i_src)
      `CSM_SRC_TERMINAL: o_merged = i_term;
      `CSM_SRC_SERIAL: o_merged = i_serial;
      `CSM_SRC_AND: o_merged = i_term & i_serial;
      `CSM_SRC_OR: o_merged = i_term | i_serial;
      default: o_merged = i_term;
    endcase
  end

endmodule

// ===== verif/csm_top_chk.sv
// port assertions for the command source merge block
`timescale 1ns/1ps
module csm_top_chk (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_reverse_terminal_input,
  input wire logic [1:0] i_setup_terminal,
  input wire logic [1:0] i_preset_terminal,
  input wire logic o_ccw,
  input wire logic [2:0] o_setup_idx,
  input wire logic [2:0] o_preset_idx
);
  // ------------------------------------------------
  // checks
  // ------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  logic wrote_ff;
  // defaults only hold until software writes anything
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wrote_ff <= 1'b0;
    end else if (i_wr) begin
      wrote_ff <= 1'b1;
    end
  end
  // first edge of reset may still see power-up values, so look from the second one on
  AST_RST_OUT: assert property (disable iff (1'b0) !i_rst_b && $past(!i_rst_b) |->
    !o_ccw && o_setup_idx == 3'h1 &&
    o_preset_idx == 3'h1 && o_rdata == 32'h0000_0000) else $error("outputs not at defaults in reset");
  AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data not zero outside read");
  AST_SRC_WIDTH: assert property ($past(i_rd) && $past(i_addr) < 4'h3 |-> o_rdata[31:2] == 30'h0)
    else $error("source register wider than two bits");
  AST_STATUS: assert property ($past(i_rd) && $past(i_addr) == 4'h4 |->
    o_rdata[6:0] == {$past(o_preset_idx), $past(o_setup_idx), $past(o_ccw)}) else $error("status mismatch");
  AST_DIR_DEF: assert property ((!wrote_ff && $stable(i_reverse_terminal_input))[*7] |->
    o_ccw == i_reverse_terminal_input) else $error("direction not from terminal");
  AST_SETUP_DEF: assert property ((!wrote_ff && $stable(i_setup_terminal))[*7] |->
    o_setup_idx == {1'b0, i_setup_terminal} + 3'h1) else $error("setup index wrong");
  AST_PRESET_DEF: assert property ((!wrote_ff && $stable(i_preset_terminal))[*7] |->
    o_preset_idx == {1'b0, i_preset_terminal} + 3'h1) else $error("preset index wrong");
  AST_HOLD: assert property (($stable({i_reverse_terminal_input, i_setup_terminal, i_preset_terminal})
    && !i_wr)[*7] |=> $stable({o_ccw, o_setup_idx, o_preset_idx})) else $error("outputs moved");
endmodule
bind csm_top csm_top_chk i_csm_top_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_reverse_terminal_input(i_reverse_terminal_input),
  .i_setup_terminal(i_setup_terminal), .i_preset_terminal(i_preset_terminal), .o_ccw(o_ccw),
  .o_setup_idx(o_setup_idx), .o_preset_idx(o_preset_idx));

// ===== verif/csm_term_model.sv
// terminal pin model for the hardwired inputs
`timescale 1ns/1ps
module csm_term_model (
  input wire logic i_clk,
  input wire logic [4:0] i_pat,
  output logic [4:0] o_pins
);
  // pins move just after an edge, never at a sampling instant
  always @(posedge i_clk) begin
    o_pins <= i_pat;
  end
endmodule

// ===== verif/tb_command_source_merge.sv
// self-checking bench for the command source merge block
`timescale 1ns/1ps
module tb_command_source_merge;
  // ------------------------------------------------
  // bench
  // ------------------------------------------------
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic rd_q = 1'b0;
  logic o_ccw;
  logic [3:0] i_addr = 4'h0;
  logic [4:0] pat = 5'h00;
  logic [4:0] pins;
  logic [2:0] o_setup_idx, o_preset_idx;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic [31:0] o_rdata;
  logic [31:0] seed = 32'h1157_2a8d;
  logic [31:0] exp_q[$];
  int n_mismatch = 0;
  int samples_checked = 0;
  csm_top i_csm_top (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_reverse_terminal_input(pins[0]), .i_setup_terminal(pins[2:1]),
    .i_preset_terminal(pins[4:3]), .o_ccw(o_ccw), .o_setup_idx(o_setup_idx), .o_preset_idx(o_preset_idx));
  csm_term_model i_csm_term_model (.i_clk(i_clk), .i_pat(pat), .o_pins(pins));
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [1:0] mrg(input logic [1:0] s, input logic [1:0] t, input logic [1:0] v);
    return s == 2'h0 ? t : s == 2'h1 ? v : s == 2'h2 ? (t & v) : (t | v);
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    exp_q.push_back(e);
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge i_clk) begin
    rd_q <= i_rd;
    if (rd_q) begin
      samples_checked++;
      if (o_rdata !== exp_q[0]) begin
        n_mismatch++;
        $display("[ERR] o_rdata expected %h seen %h", exp_q[0], o_rdata);
      end
      void'(exp_q.pop_front());
    end
  end
  // hang guard, far beyond the roughly 740 cycles needed
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    logic [4:0] p, c;
    logic [31:0] e;
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (12) @(posedge i_clk);
    rd(4'h1, 32'h0000_0003);
    rd(4'h2, 32'h0000_0003);
    rd(4'h0, 32'h0000_0000);
    rd(4'h5, 32'h0000_0000);
    for (int s = 0; s < 4; s++) begin
      for (int a = 0; a < 3; a++) begin
        wr(a[3:0], {seed[31:2], s[1:0]});
        rd(a[3:0], {30'h0, s[1:0]});
      end
      repeat (16) begin
        seed = lfsr(seed);
        p = seed[4:0];
        c = seed[9:5];
        @(posedge i_clk);
        pat <= p;
        wr(4'h3, {27'h0, c});
        repeat (5) @(posedge i_clk);
        e = {20'h0, p, {1'b0, mrg(s[1:0], p[4:3], c[4:3])} + 3'h1,
          {1'b0, mrg(s[1:0], p[2:1], c[2:1])} + 3'h1, |mrg(s[1:0], {1'b0, p[0]}, {1'b0, c[0]})};
        rd(4'h4, e);
        samples_checked++;
        // the output pins themselves, not only their copy in the status word
        if ({o_preset_idx, o_setup_idx, o_ccw} !== e[6:0]) begin
          n_mismatch++;
          $display("[ERR] outputs expected %h seen %h", e[6:0], {o_preset_idx, o_setup_idx, o_ccw});
        end
      end
    end
    // let the last read answer land before reset clears the read data
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (12) @(posedge i_clk);
    rd(4'h1, 32'h0000_0003);
    rd(4'h3, 32'h0000_0000);
    repeat (3) @(posedge i_clk);
    report_and_stop();
  end
endmodule
